// ---- src/ccd_timing_pkg.sv ----
// Constants for the line and frame sequencer that drives an interline CCD.
// Assumes a 10 MHz system clock; one horizontal clock pair per two cycles.
package ccd_timing_pkg;
	localparam int CLK_MHZ = 10;
	localparam int DARK_TOP_ROWS = 10;
	localparam int ACTIVE_ROWS = 2062;
	localparam int BUF_ROWS_FIRST = 6;
	localparam int BUF_ROWS_LAST = 8;
	localparam int IMAGE_ROWS = 2048;
	localparam int EMPTY_PIX = 12;
	localparam int DARK_PIX = 28;
	localparam int PHOTO_PIX_SINGLE = 2056;
	localparam int PHOTO_PIX_DUAL = 1028;
	localparam int BUF_PIX = 4;
	localparam int HCLK_SINGLE = 2124;
	localparam int HCLK_DUAL = 1068;
	localparam int VPULSE_NS = 1000;
	localparam int VPULSE_CYC = (VPULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int HSTART_DELAY_NS = 1000;
	localparam int HSTART_CYC = (HSTART_DELAY_NS * CLK_MHZ + 999) / 1000;
	// Pixel class codes
	localparam logic [2:0] CLS_EMPTY = 3'h0;
	localparam logic [2:0] CLS_DARK_EDGE = 3'h1;
	localparam logic [2:0] CLS_DARK_REF = 3'h2;
	localparam logic [2:0] CLS_BUFFER = 3'h3;
	localparam logic [2:0] CLS_IMAGE = 3'h4;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_VXFER = 5'h02,
		ST_HDELAY = 5'h04,
		ST_HSHIFT = 5'h08,
		ST_DONE = 5'h10
	} seq_state_t;
endpackage

// ---- src/pix_fifo.sv ----
// Small FIFO carrying pixel-class tags towards downstream capture logic.
// Assumes one clock; reader may stall at will.
`timescale 1ns/1ps
`default_nettype none
module pix_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Write side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Read side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_ff;
	logic [AW-1:0] rp_ff;
	logic [AW:0] cnt_ff;
	logic wr;
	logic rd;
	logic [AW-1:0] nxt_rp;
	logic [AW:0] nxt_cnt;
	assign wr = in_valid && in_ready;
	assign rd = out_valid && out_ready;
	assign nxt_rp = (rd && rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + AW'(rd);
	assign nxt_cnt = cnt_ff + (AW+1)'(wr) - (AW+1)'(rd);
	// Flags are registered from the next count and the head word from the next read pointer so the ports come from flops
	always_ff @(posedge clk)
	begin
		if (wr)
			mem[wp_ff] <= in_data;
		if (rst)
		begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
			out_data <= '0;
		end
		else
		begin
			if (wr)
				wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
			rp_ff <= nxt_rp;
			cnt_ff <= nxt_cnt;
			in_ready <= nxt_cnt != (AW+1)'(DEPTH);
			out_valid <= nxt_cnt != '0;
			// A word landing in the head slot is not in the array yet
			out_data <= (wr && wp_ff == nxt_rp) ? in_data : mem[nxt_rp];
		end
	end
endmodule
`default_nettype wire

// ---- src/ccd_readout_timing.sv ----
// Timing generator that sequences frame and line readout of an interline CCD.
// Assumes the sensor pins are driven by external clock drivers from these outputs.
// Overview of operation
// - Dual mode reverses right half; each half leaves its own output.
// - Receiver reverses right-output line and appends it after left line.
// - Dark level comes from 28 dark columns, never the bottom dark rows.
// - Only the central 26 of 28 dark columns feed the zero level.
// - During vertical shift, horizontal phase A held high and B low.
// - Horizontal clocks resume only after start delay following vertical fall.
// - No shutter, vertical or line-dump pulses while horizontal shifting.
// - Two halves of 1,068 cells: same direction single, opposite dual.
// - Barrier phase wiring sets each half's shift direction.
// - Single mode: phase A drives storage_a both, barrier_a_left, barrier_b_right.
// - Dual mode 1,068 horizontal clocks per line; single mode 2,124.
// - Separately inverted right barrier clocks align within 3 ns.
`timescale 1ns/1ps
`default_nettype none
module ccd_readout_timing
	import ccd_timing_pkg::*;
#(
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic start_frame,
	input wire logic dual_mode,
	input wire logic dump_rows,
	output logic busy,
	// Sensor timing outputs
	output logic vertical_phase_a,
	output logic vertical_phase_b,
	output logic storage_a_left,
	output logic storage_b_left,
	output logic storage_a_right,
	output logic storage_b_right,
	output logic barrier_a_left,
	output logic barrier_b_left,
	output logic barrier_a_right,
	output logic barrier_b_right,
	output logic line_dump,
	output logic shutter_drain,
	// Pixel tag stream: {row_image, line_first, class[2:0], pix[10:0]}
	output logic tag_valid,
	input wire logic tag_ready,
	output logic [15:0] tag_data
);
	typedef struct packed {
		seq_state_t st;
		logic [11:0] row;
		logic [11:0] pix;
		logic [11:0] dly;
		logic dual;
		logic dump;
		logic ha;
		logic va;
		logic ld;
		logic [11:0] s_a;
		logic push;
		logic [15:0] tag;
		logic bsy;
	} state_t;
	state_t cur_ff;
	state_t nxt_ff;
	logic fifo_ready;
	logic [11:0] s_left;

	// Pixel class from position along a line of one output
	function automatic logic [2:0] pix_class(input logic [11:0] p, input logic dual);
		logic [11:0] q;
		q = p - 12'(EMPTY_PIX);
		if (p < 12'(EMPTY_PIX))
			return CLS_EMPTY;
		if (q < 12'(DARK_PIX))
			return (q == 12'h0 || q == 12'(DARK_PIX-1)) ? CLS_DARK_EDGE : CLS_DARK_REF;
		q = q - 12'(DARK_PIX);
		if (dual)
			return (q < 12'(BUF_PIX)) ? CLS_BUFFER : CLS_IMAGE;
		if (q < 12'(PHOTO_PIX_SINGLE))
			return (q < 12'(BUF_PIX) || q >= 12'(PHOTO_PIX_SINGLE-BUF_PIX))
				? CLS_BUFFER : CLS_IMAGE;
		q = q - 12'(PHOTO_PIX_SINGLE);
		return (q == 12'h0 || q == 12'(DARK_PIX-1)) ? CLS_DARK_EDGE : CLS_DARK_REF;
	endfunction

	always_comb
	begin
		nxt_ff = cur_ff;
		nxt_ff.push = 1'b0;
		s_left = 12'(HCLK_SINGLE);
		case (cur_ff.st)
			ST_IDLE:
			begin
				nxt_ff.ha = 1'b1;
				nxt_ff.bsy = 1'b0;
				if (start_frame)
				begin
					nxt_ff.dual = dual_mode;
					nxt_ff.dump = dump_rows;
					nxt_ff.row = '0;
					nxt_ff.dly = '0;
					nxt_ff.bsy = 1'b1;
					nxt_ff.va = 1'b1;
					nxt_ff.ld = dump_rows;
					nxt_ff.st = ST_VXFER;
				end
			end
			ST_VXFER:
			begin
				nxt_ff.ha = 1'b1;
				nxt_ff.dly = cur_ff.dly + 12'h1;
				if (cur_ff.dly == 12'(VPULSE_CYC-1))
				begin
					nxt_ff.va = 1'b0;
					nxt_ff.ld = 1'b0;
					nxt_ff.dly = '0;
					nxt_ff.st = ST_HDELAY;
				end
			end
			ST_HDELAY:
			begin
				nxt_ff.dly = cur_ff.dly + 12'h1;
				if (cur_ff.dly == 12'(HSTART_CYC-1))
				begin
					nxt_ff.pix = '0;
					nxt_ff.st = ST_HSHIFT;
				end
			end
			ST_HSHIFT:
			begin
				// Stall the horizontal clock while the tag FIFO is full
				if (fifo_ready)
				begin
					nxt_ff.ha = ~cur_ff.ha;
					if (cur_ff.ha)
					begin
						nxt_ff.push = 1'b1;
						nxt_ff.tag = {cur_ff.row >= 12'(DARK_TOP_ROWS+BUF_ROWS_FIRST)
							&& cur_ff.row < 12'(DARK_TOP_ROWS+BUF_ROWS_FIRST+IMAGE_ROWS),
							cur_ff.pix == 12'h0, pix_class(cur_ff.pix, cur_ff.dual),
							cur_ff.pix[10:0]};
						nxt_ff.pix = cur_ff.pix + 12'h1;
					end
					else if (cur_ff.pix == (cur_ff.dual ? 12'(HCLK_DUAL) : s_left))
					begin
						nxt_ff.ha = 1'b1;
						nxt_ff.row = cur_ff.row + 12'h1;
						nxt_ff.dly = '0;
						if (cur_ff.row == 12'(DARK_TOP_ROWS+ACTIVE_ROWS-1))
							nxt_ff.st = ST_DONE;
						else
						begin
							nxt_ff.va = 1'b1;
							nxt_ff.ld = cur_ff.dump;
							nxt_ff.st = ST_VXFER;
						end
					end
				end
			end
			ST_DONE:
			begin
				nxt_ff.bsy = 1'b0;
				nxt_ff.st = ST_IDLE;
			end
			default:
				nxt_ff.st = ST_IDLE;
		endcase
		if (rst)
		begin
			nxt_ff = '0;
			nxt_ff.st = ST_IDLE;
			nxt_ff.ha = 1'b1;
		end
	end

	always_ff @(posedge clk)
		cur_ff <= nxt_ff;

	// Phase A fills storage_a first; barriers follow storage by mode
	always_ff @(posedge clk)
	begin
		vertical_phase_a <= nxt_ff.va;
		vertical_phase_b <= nxt_ff.va;
		line_dump <= nxt_ff.ld;
		shutter_drain <= 1'b0;
		busy <= nxt_ff.bsy;
		storage_a_left <= nxt_ff.ha;
		storage_b_left <= ~nxt_ff.ha;
		storage_a_right <= nxt_ff.ha;
		storage_b_right <= ~nxt_ff.ha;
		barrier_a_left <= nxt_ff.ha;
		barrier_b_left <= ~nxt_ff.ha;
		// Swapping right barriers reverses the right half; same register edge keeps skew low
		barrier_a_right <= nxt_ff.dual ? nxt_ff.ha : ~nxt_ff.ha;
		barrier_b_right <= nxt_ff.dual ? ~nxt_ff.ha : nxt_ff.ha;
	end

	pix_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(cur_ff.push),
		.in_ready(fifo_ready),
		.in_data(cur_ff.tag),
		.out_valid(tag_valid),
		.out_ready(tag_ready),
		.out_data(tag_data)
	);

	a_vert_hold_ha: assert property (@(posedge clk) disable iff (rst)
		vertical_phase_a |-> storage_a_left && !storage_b_left)
		else $error("horizontal not parked during vertical shift");
	a_no_pulse_shift: assert property (@(posedge clk) disable iff (rst)
		cur_ff.st == ST_HSHIFT |-> !vertical_phase_a && !line_dump && !shutter_drain)
		else $error("pulse during horizontal shift");
	// Cycles since the vertical pulse ended, saturating; watches the pins, not the sequencer
	logic [11:0] since_v_ff;
	always_ff @(posedge clk)
	begin
		if (rst || vertical_phase_a)
			since_v_ff <= '0;
		else if (since_v_ff != 12'hfff)
			since_v_ff <= since_v_ff + 12'h1;
	end
	a_start_delay: assert property (@(posedge clk) disable iff (rst)
		$fell(storage_a_left) |-> since_v_ff >= 12'(HSTART_CYC))
		else $error("horizontal resumed before start delay");
	a_right_dir: assert property (@(posedge clk) disable iff (rst)
		barrier_a_right == (cur_ff.dual ? storage_a_left : storage_b_left))
		else $error("right barrier direction wrong");
	a_dump_with_v: assert property (@(posedge clk) disable iff (rst)
		line_dump |-> vertical_phase_a)
		else $error("line dump outside transfer");
	a_count_bound: assert property (@(posedge clk) disable iff (rst)
		cur_ff.pix <= 12'(HCLK_SINGLE))
		else $error("horizontal count overrun");
	a_rows_bound: assert property (@(posedge clk) disable iff (rst)
		cur_ff.row <= 12'(DARK_TOP_ROWS+ACTIVE_ROWS))
		else $error("row count overrun");
	a_vpulse_len: assert property (@(posedge clk) disable iff (rst)
		$rose(cur_ff.va) |-> cur_ff.va [*1] ##(VPULSE_CYC) !cur_ff.va)
		else $error("vertical pulse length wrong");
	c_frame_start: cover property (@(posedge clk) disable iff (rst) cur_ff.st == ST_VXFER);
	c_dual_line: cover property (@(posedge clk) disable iff (rst)
		cur_ff.dual && cur_ff.st == ST_HSHIFT);
	c_fifo_stall: cover property (@(posedge clk) disable iff (rst)
		cur_ff.st == ST_HSHIFT && !fifo_ready);
endmodule
`default_nettype wire

// ---- tb/ccd_sensor_model.sv ----
// Behavioural sensor: counts row transfers and horizontal clock pairs per line.
// Assumes the controller's timing outputs drive it directly; it has no clock.
`timescale 1ns/1ps
`default_nettype none
module ccd_sensor_model (
	// Vertical and dump inputs
	input wire logic vertical_phase_a,
	input wire logic line_dump,
	// Horizontal phases
	input wire logic storage_a_left,
	input wire logic storage_b_left,
	// Observed counts
	output var int rows_shifted,
	output var int rows_loaded,
	output var int hclk_now,
	output var int hclk_line,
	output var int gap_ns,
	output var int stop_faults
);
	realtime fall_t;
	initial
	begin
		rows_shifted = 0;
		rows_loaded = 0;
		hclk_now = 0;
		hclk_line = 0;
		gap_ns = 0;
		stop_faults = 0;
	end
	// A dumped row never reaches the horizontal register
	always @(posedge vertical_phase_a)
	begin
		// Dump and horizontal phases change on the same edge; let them settle first
		#1;
		rows_shifted++;
		if (line_dump !== 1'b1)
			rows_loaded++;
		if (storage_a_left !== 1'b1 || storage_b_left !== 1'b0)
			stop_faults++;
	end
	always @(negedge vertical_phase_a)
		fall_t = $realtime;
	// One pair per falling phase A edge; a new row restarts the count
	always @(negedge storage_a_left or posedge vertical_phase_a)
		if (vertical_phase_a)
		begin
			hclk_line = hclk_now;
			hclk_now = 0;
		end
		else
		begin
			if (hclk_now == 0)
				gap_ns = int'($realtime - fall_t);
			hclk_now++;
		end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the CCD readout sequencer with a sensor model.
// Assumes a full frame is too long to run; each scenario shifts one row, and the dump scenario reads none.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ccd_timing_pkg::*;
	logic clk = 0, rst = 1, start_frame = 0, dual_mode = 0, dump_rows = 0, tag_ready = 1;
	logic busy, vertical_phase_a, vertical_phase_b, storage_a_left, storage_b_left;
	logic storage_a_right, storage_b_right, barrier_a_left, barrier_b_left;
	logic barrier_a_right, barrier_b_right, line_dump, shutter_drain, tag_valid;
	logic [15:0] tag_data;
	int rows_shifted, rows_loaded, hclk_now, hclk_line, gap_ns, stop_faults;
	int errors = 0, checks_done = 0;
	always #50 clk = ~clk;
	ccd_readout_timing #(.FIFO_DEPTH(8)) DUT (.clk(clk), .rst(rst), .start_frame(start_frame),
		.dual_mode(dual_mode), .dump_rows(dump_rows), .busy(busy),
		.vertical_phase_a(vertical_phase_a), .vertical_phase_b(vertical_phase_b),
		.storage_a_left(storage_a_left), .storage_b_left(storage_b_left),
		.storage_a_right(storage_a_right), .storage_b_right(storage_b_right),
		.barrier_a_left(barrier_a_left), .barrier_b_left(barrier_b_left),
		.barrier_a_right(barrier_a_right), .barrier_b_right(barrier_b_right),
		.line_dump(line_dump), .shutter_drain(shutter_drain), .tag_valid(tag_valid),
		.tag_ready(tag_ready), .tag_data(tag_data));
	ccd_sensor_model sensor (.vertical_phase_a(vertical_phase_a), .line_dump(line_dump),
		.storage_a_left(storage_a_left), .storage_b_left(storage_b_left),
		.rows_shifted(rows_shifted), .rows_loaded(rows_loaded), .hclk_now(hclk_now),
		.hclk_line(hclk_line), .gap_ns(gap_ns), .stop_faults(stop_faults));
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] act, input logic [31:0] exp);
		checks_done++;
		if (act !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, act, exp);
		end
	endtask
	// Class of a horizontal position; a dual line ends before the right dark columns
	function automatic logic [2:0] cls_of(input int p);
		int dl = EMPTY_PIX + DARK_PIX;
		int dr = dl + PHOTO_PIX_SINGLE;
		if (p < EMPTY_PIX)
			return CLS_EMPTY;
		if (p == EMPTY_PIX || p == dl - 1 || p == dr || p == HCLK_SINGLE - 1)
			return CLS_DARK_EDGE;
		if (p < dl || p >= dr)
			return CLS_DARK_REF;
		if (p < dl + BUF_PIX || p >= dr - BUF_PIX)
			return CLS_BUFFER;
		return CLS_IMAGE;
	endfunction
	task automatic wait_vert(input logic lvl);
		int n = 0;
		while (vertical_phase_a !== lvl)
		begin
			@(posedge clk);
			if (++n > 6000)
			begin
				errors++;
				conclude();
			end
		end
	endtask
	task automatic restart(input logic dual, input logic dump);
		rst <= 1;
		repeat (20) @(posedge clk);
		rst <= 0;
		dual_mode <= dual;
		dump_rows <= dump;
		@(posedge clk);
		check(storage_a_left, 1);
		check({vertical_phase_a, busy, tag_valid, shutter_drain}, 0);
		start_frame <= 1;
		@(posedge clk);
		start_frame <= 0;
	endtask
	// Reads one full line; optionally stalls the tag reader part way through
	task automatic run_line(input logic dual, input int stall);
		int n = 0, w = 0, k = 0, h0;
		wait_vert(1);
		check({vertical_phase_b, line_dump}, 2'b10);
		repeat (VPULSE_CYC) @(posedge clk);
		check(vertical_phase_a, 0);
		while (w < 8)
		begin
			@(posedge clk);
			if (++k > 6000)
			begin
				errors++;
				conclude();
			end
			if (tag_valid === 1'b1 && tag_ready === 1'b1)
			begin
				check(tag_data[10:0], n[10:0]);
				check(tag_data[15:11], {1'b0, n == 0, cls_of(n)});
				n++;
			end
			check({busy, storage_b_left, barrier_a_left, barrier_b_left, storage_a_right,
				storage_b_right}, {1'b1, !storage_a_left, storage_a_left, !storage_a_left,
				storage_a_left, !storage_a_left});
			if (dual)
				check({barrier_a_right, barrier_b_right}, {storage_a_left, storage_b_left});
			else
				check({barrier_a_right, barrier_b_right}, {storage_b_left, storage_a_left});
			if (n == stall && stall > 0)
			begin
				tag_ready <= 0;
				repeat (20) @(posedge clk);
				h0 = hclk_now;
				repeat (30) @(posedge clk);
				check(hclk_now, h0);
				check(tag_valid, 1);
				tag_ready <= 1;
			end
			if (vertical_phase_a === 1'b1 || n > HCLK_SINGLE + 4)
				w++;
		end
		check(n, dual ? HCLK_DUAL : HCLK_SINGLE);
		check(hclk_line, dual ? HCLK_DUAL : HCLK_SINGLE);
		check(gap_ns >= HSTART_DELAY_NS, 1);
		check(stop_faults, 0);
	endtask
	task automatic dump_row();
		int s0, l0;
		restart(0, 1);
		s0 = rows_shifted;
		l0 = rows_loaded;
		wait_vert(1);
		check(line_dump, 1);
		wait_vert(0);
		check(rows_shifted - s0, 1);
		check(rows_loaded - l0, 0);
	endtask
	initial
	begin
		restart(0, 0);
		run_line(0, 0);
		restart(1, 0);
		run_line(1, 300);
		dump_row();
		conclude();
	end
endmodule
`default_nettype wire
